// *** logic/timer_tcw_pkg.sv ***
// Function
// - Trigger zeroes counter, starts clock at tick
// - Software trigger command triggers this channel
// - Block sync command acts as software trigger
// - Period compare match triggers when enabled, capture mode only
// - Waveform bit clear selects capture, inputs only
// - Capture A/B load on chosen line-A edges
// - A loads first or after B loaded
// - B loads only after A loaded
// - Reload before read overwrites, sets overrun flag
// - Capture trigger line and edge, zero disables
// - Waveform mode drives line A, maybe B
// - Scheme 00 counts up full range, wraps
// - Scheme 10 counts up to period, resets
// - Scheme 01 counts up/down full range
// - Scheme 11 counts up/down to period
// - Up/down trigger reverses count direction
// - Period match stops or disables counter clock
// - Event select, event edge, event trigger enable
// - Event on line B frees line B output
// - Output controller set/clear/toggle per event
// - Gray enable drives 2-bit gray on A/B
// - Start/stop only while clock enabled
// - Select 0 picks line B, 1 line A
package timer_tcw_pkg;

    localparam int unsigned CNT_W = 32;

    // Edge selection codes shared by load, trigger and event fields
    localparam logic [1:0] EDGE_NONE = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_FALL = 2'h2;
    localparam logic [1:0] EDGE_BOTH = 2'h3;

    // Counting schemes; bit 0 means up/down, bit 1 means period-limited
    localparam logic [1:0] SCHEME_UP_FULL = 2'h0;
    localparam logic [1:0] SCHEME_UPDN_FULL = 2'h1;
    localparam logic [1:0] SCHEME_UP_PERIOD = 2'h2;
    localparam logic [1:0] SCHEME_UPDN_PERIOD = 2'h3;

    // External event sources
    localparam logic [1:0] EVT_LINE_B = 2'h0;
    localparam logic [1:0] EVT_CLK_0 = 2'h1;
    localparam logic [1:0] EVT_CLK_1 = 2'h2;
    localparam logic [1:0] EVT_CLK_2 = 2'h3;

    // Output controller actions
    localparam logic [1:0] ACT_NONE = 2'h0;
    localparam logic [1:0] ACT_SET = 2'h1;
    localparam logic [1:0] ACT_CLEAR = 2'h2;
    localparam logic [1:0] ACT_TOGGLE = 2'h3;

    localparam logic [CNT_W-1:0] CNT_ZERO = 32'h0000_0000;
    localparam logic [CNT_W-1:0] CNT_ONE = 32'h0000_0001;
    localparam logic [CNT_W-1:0] CNT_MAX = 32'hFFFF_FFFF;

    function automatic logic edge_hit(input logic [1:0] sel,
                                      input logic cur,
                                      input logic prev);
        return (sel == EDGE_RISE && cur && !prev) ||
               (sel == EDGE_FALL && !cur && prev) ||
               (sel == EDGE_BOTH && cur != prev);
    endfunction : edge_hit

    function automatic logic apply_act(input logic lvl,
                                       input logic [1:0] act,
                                       input logic hit);
        logic r;
        r = lvl;
        if (hit) begin
            case (act)
                ACT_SET: r = 1'b1;
                ACT_CLEAR: r = 1'b0;
                ACT_TOGGLE: r = !lvl;
                default: r = lvl;
            endcase
        end
        return r;
    endfunction : apply_act

endpackage : timer_tcw_pkg

// *** logic/timer_trigger_capture_waveform.sv ***
`timescale 1ns/1ns
module timer_trigger_capture_waveform
    import timer_tcw_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    // Command pulses
    input wire logic clk_enable_cmd,
    input wire logic clk_disable_cmd,
    input wire logic software_trigger_cmd,
    input wire logic block_sync_cmd,
    input wire logic capture_a_read,
    input wire logic capture_b_read,
    input wire logic status_read,
    // Mode configuration
    input wire logic wave_mode,
    input wire logic period_compare_trigger_en,
    input wire logic [1:0] capture_a_load_edge,
    input wire logic [1:0] capture_b_load_edge,
    input wire logic ab_trigger_select,
    input wire logic [1:0] capture_trigger_edge,
    input wire logic [1:0] ext_event_select,
    input wire logic [1:0] ext_event_edge,
    input wire logic ext_event_trigger_en,
    input wire logic [1:0] count_scheme_select,
    input wire logic period_compare_stop,
    input wire logic period_compare_disable,
    input wire logic gray_count_enable,
    input wire logic gray_count_down,
    // Output controller actions
    input wire logic [1:0] a_act_compare_a,
    input wire logic [1:0] a_act_period,
    input wire logic [1:0] a_act_event,
    input wire logic [1:0] a_act_sw_trigger,
    input wire logic [1:0] b_act_compare_b,
    input wire logic [1:0] b_act_period,
    input wire logic [1:0] b_act_event,
    input wire logic [1:0] b_act_sw_trigger,
    // Compare values
    input wire logic [CNT_W-1:0] compare_a_value,
    input wire logic [CNT_W-1:0] compare_b_value,
    input wire logic [CNT_W-1:0] period_compare_value,
    // Selected counter clock, one cycle per active edge
    input wire logic count_tick,
    // External lines
    input wire logic ext_clock_0,
    input wire logic ext_clock_1,
    input wire logic ext_clock_2,
    input wire logic timer_line_a_in,
    input wire logic timer_line_b_in,
    output logic timer_line_a_out,
    output logic timer_line_a_oe,
    output logic timer_line_b_out,
    output logic timer_line_b_oe,
    // Status
    output logic [CNT_W-1:0] counter_value_reg,
    output logic [CNT_W-1:0] capture_a_reg,
    output logic [CNT_W-1:0] capture_b_value,
    output logic load_overrun_flag,
    output logic counter_clock_enabled,
    output logic counter_clock_running
);

    typedef struct packed {
        logic [CNT_W-1:0] cv;
        logic [CNT_W-1:0] ra;
        logic [CNT_W-1:0] rb;
        logic clk_en;
        logic clk_run;
        logic trig_pend;
        logic dir_down;
        logic expect_b;
        logic ra_unread;
        logic rb_unread;
        logic ovr;
        logic a_prev;
        logic b_prev;
        logic x0_prev;
        logic x1_prev;
        logic x2_prev;
        logic [1:0] gray;
        logic a_out;
        logic b_out;
        logic a_oe;
        logic b_oe;
    } state_t;

    state_t s_q;
    state_t s_d;

    logic tick_run;
    logic cap_src;
    logic cap_prev;
    logic cap_trig;
    logic ev_cur;
    logic ev_prev;
    logic ext_evt;
    logic sw_trig;
    logic rc_match;
    logic rc_trig;
    logic any_trig;
    logic apply_trig;
    logic updown;
    logic b_is_out;
    logic ld_a;
    logic ld_b;
    logic ra_match;
    logic rb_match;
    logic [CNT_W-1:0] top;

    always_comb begin
        s_d = s_q;
        tick_run = count_tick && s_q.clk_en && s_q.clk_run;
        updown = count_scheme_select[0];
        top = count_scheme_select[1] ? period_compare_value : CNT_MAX;
        b_is_out = wave_mode && ext_event_select != EVT_LINE_B;

        // Capture-mode external trigger source
        cap_src = ab_trigger_select ? timer_line_a_in : timer_line_b_in;
        cap_prev = ab_trigger_select ? s_q.a_prev : s_q.b_prev;
        cap_trig = !wave_mode &&
                   edge_hit(capture_trigger_edge, cap_src, cap_prev);

        // Waveform-mode external event source
        case (ext_event_select)
            EVT_LINE_B: begin
                ev_cur = timer_line_b_in;
                ev_prev = s_q.b_prev;
            end
            EVT_CLK_0: begin
                ev_cur = ext_clock_0;
                ev_prev = s_q.x0_prev;
            end
            EVT_CLK_1: begin
                ev_cur = ext_clock_1;
                ev_prev = s_q.x1_prev;
            end
            default: begin
                ev_cur = ext_clock_2;
                ev_prev = s_q.x2_prev;
            end
        endcase
        ext_evt = wave_mode && edge_hit(ext_event_edge, ev_cur, ev_prev);

        // Sampled once per clock; one-cycle pulses need from outside
        sw_trig = software_trigger_cmd || block_sync_cmd;
        rc_match = tick_run && s_q.cv == period_compare_value;
        // In waveform mode the period reset lives in the counting scheme
        rc_trig = rc_match && !wave_mode && period_compare_trigger_en;
        any_trig = sw_trig || cap_trig ||
                   (ext_evt && ext_event_trigger_en);

        // Triggers wait for the next active counter edge; a period match
        // is already seen on a tick, so it zeroes at that very edge
        apply_trig = (count_tick && s_q.trig_pend) || rc_trig;
        s_d.trig_pend = (s_q.trig_pend && !count_tick) || any_trig;

        if (apply_trig) begin
            if (s_q.clk_en) begin
                s_d.clk_run = 1'b1;
            end
            if (wave_mode && updown) begin
                // Direction flips; the count resumes from where it stood
                s_d.dir_down = !s_q.dir_down;
            end else begin
                s_d.cv = CNT_ZERO;
            end
            s_d.expect_b = 1'b0;
        end else if (tick_run) begin
            if (!wave_mode || count_scheme_select == SCHEME_UP_FULL) begin
                s_d.cv = s_q.cv + CNT_ONE;
            end else if (count_scheme_select == SCHEME_UP_PERIOD) begin
                s_d.cv = rc_match ? CNT_ZERO : s_q.cv + CNT_ONE;
            end else if (top == CNT_ZERO) begin
                // Degenerate period: hold at zero rather than underflow
                s_d.cv = CNT_ZERO;
                s_d.dir_down = 1'b0;
            end else if (!s_q.dir_down) begin
                if (s_q.cv >= top) begin
                    s_d.dir_down = 1'b1;
                    s_d.cv = s_q.cv - CNT_ONE;
                end else begin
                    s_d.cv = s_q.cv + CNT_ONE;
                end
            end else begin
                if (s_q.cv == CNT_ZERO) begin
                    s_d.dir_down = 1'b0;
                    s_d.cv = CNT_ONE;
                end else begin
                    s_d.cv = s_q.cv - CNT_ONE;
                end
            end
        end

        // Period compare stop/disable in waveform mode
        if (wave_mode && rc_match && s_q.clk_en) begin
            if (period_compare_stop) begin
                s_d.clk_run = 1'b0;
            end
            if (period_compare_disable) begin
                s_d.clk_en = 1'b0;
            end
        end

        // Disable wins over enable in the same command
        if (clk_disable_cmd) begin
            s_d.clk_en = 1'b0;
        end else if (clk_enable_cmd) begin
            s_d.clk_en = 1'b1;
        end

        // Capture loads; the sequence bit keeps A and B alternating
        ld_a = !wave_mode && !s_q.expect_b &&
               edge_hit(capture_a_load_edge, timer_line_a_in,
                        s_q.a_prev);
        ld_b = !wave_mode && s_q.expect_b &&
               edge_hit(capture_b_load_edge, timer_line_a_in,
                        s_q.a_prev);
        if (capture_a_read) begin
            s_d.ra_unread = 1'b0;
        end
        if (capture_b_read) begin
            s_d.rb_unread = 1'b0;
        end
        if (status_read) begin
            s_d.ovr = 1'b0;
        end
        if (ld_a) begin
            s_d.ra = s_q.cv;
            s_d.expect_b = 1'b1;
            s_d.ra_unread = 1'b1;
            if (s_q.ra_unread && !capture_a_read) begin
                s_d.ovr = 1'b1;
            end
        end
        if (ld_b) begin
            s_d.rb = s_q.cv;
            s_d.expect_b = 1'b0;
            s_d.rb_unread = 1'b1;
            if (s_q.rb_unread && !capture_b_read) begin
                s_d.ovr = 1'b1;
            end
        end

        // Output controller; later events take priority over earlier ones
        ra_match = tick_run && s_q.cv == compare_a_value;
        rb_match = tick_run && s_q.cv == compare_b_value && b_is_out;
        if (wave_mode && gray_count_enable) begin
            if (rc_match) begin
                s_d.gray = gray_count_down ? s_q.gray - 2'h1
                                           : s_q.gray + 2'h1;
            end
            s_d.a_out = s_d.gray[1] ^ s_d.gray[0];
            s_d.b_out = s_d.gray[1];
        end else if (wave_mode) begin
            s_d.a_out = apply_act(s_d.a_out, a_act_compare_a,
                                  ra_match);
            s_d.a_out = apply_act(s_d.a_out, a_act_period, rc_match);
            s_d.a_out = apply_act(s_d.a_out, a_act_event, ext_evt);
            s_d.a_out = apply_act(s_d.a_out, a_act_sw_trigger,
                                  sw_trig);
            if (b_is_out) begin
                s_d.b_out = apply_act(s_d.b_out, b_act_compare_b,
                                      rb_match);
                s_d.b_out = apply_act(s_d.b_out, b_act_period, rc_match);
                s_d.b_out = apply_act(s_d.b_out, b_act_event, ext_evt);
                s_d.b_out = apply_act(s_d.b_out, b_act_sw_trigger,
                                      sw_trig);
            end
        end
        s_d.a_oe = wave_mode;
        s_d.b_oe = b_is_out;

        s_d.a_prev = timer_line_a_in;
        s_d.b_prev = timer_line_b_in;
        s_d.x0_prev = ext_clock_0;
        s_d.x1_prev = ext_clock_1;
        s_d.x2_prev = ext_clock_2;
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign counter_value_reg = s_q.cv;
    assign capture_a_reg = s_q.ra;
    assign capture_b_value = s_q.rb;
    assign load_overrun_flag = s_q.ovr;
    assign counter_clock_enabled = s_q.clk_en;
    assign counter_clock_running = s_q.clk_run;
    assign timer_line_a_out = s_q.a_out;
    assign timer_line_a_oe = s_q.a_oe;
    assign timer_line_b_out = s_q.b_out;
    assign timer_line_b_oe = s_q.b_oe;

endmodule : timer_trigger_capture_waveform

// *** sim/timer_tcw_checker.sv ***
`timescale 1ns/1ns
module timer_tcw_checker
    import timer_tcw_pkg::*;
(
    // Clock, reset and watched inputs
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic clk_enable_cmd,
    input wire logic clk_disable_cmd,
    input wire logic status_read,
    input wire logic wave_mode,
    input wire logic [1:0] ext_event_select,
    input wire logic [1:0] ext_event_edge,
    input wire logic count_tick,
    // Watched outputs
    input wire logic timer_line_a_oe,
    input wire logic timer_line_b_oe,
    input wire logic [CNT_W-1:0] counter_value_reg,
    input wire logic [CNT_W-1:0] capture_a_reg,
    input wire logic [CNT_W-1:0] capture_b_value,
    input wire logic load_overrun_flag,
    input wire logic counter_clock_enabled,
    input wire logic counter_clock_running
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);

    reset_clears_all_a: assert property ($fell(srst) |->
        !timer_line_a_oe && !timer_line_b_oe &&
        counter_value_reg == CNT_ZERO && !counter_clock_enabled &&
        !load_overrun_flag)
        else $error("outputs not cleared by reset");
    capture_lines_in_a: assert property (
        !wave_mode && !$past(wave_mode) |->
        !timer_line_a_oe && !timer_line_b_oe)
        else $error("line driven in capture mode");
    wave_drives_a_a: assert property (
        wave_mode && $past(wave_mode) && !$past(srst) |-> timer_line_a_oe)
        else $error("line A not driven in waveform mode");
    line_b_event_a: assert property (
        wave_mode && $past(wave_mode) && !$past(srst) &&
        $stable(ext_event_select) && $stable(ext_event_edge) &&
        (ext_event_select != EVT_LINE_B || ext_event_edge != EDGE_NONE)
        |-> timer_line_b_oe == (ext_event_select != EVT_LINE_B))
        else $error("line B drive does not follow event select");
    disable_cmd_a: assert property (
        clk_disable_cmd |=> !counter_clock_enabled)
        else $error("clock still enabled after disable");
    stays_off_a: assert property (
        !counter_clock_enabled && !clk_enable_cmd |=> !counter_clock_enabled)
        else $error("clock enabled without enable command");
    start_when_en_a: assert property (
        $rose(counter_clock_running) |-> $past(counter_clock_enabled))
        else $error("clock started while disabled");
    idle_counter_a: assert property (
        !count_tick |=> $stable(counter_value_reg))
        else $error("counter moved without a tick");
    overrun_sticky_a: assert property (
        load_overrun_flag && !status_read |=> load_overrun_flag)
        else $error("overrun flag lost without status read");
    capture_hold_a: assert property (
        wave_mode ##1 wave_mode |->
        $stable(capture_a_reg) && $stable(capture_b_value))
        else $error("capture loaded in waveform mode");
endmodule : timer_tcw_checker

bind timer_trigger_capture_waveform timer_tcw_checker timer_tcw_checker_inst (
    .clk_sys(clk_sys), .srst(srst), .clk_enable_cmd(clk_enable_cmd),
    .clk_disable_cmd(clk_disable_cmd), .status_read(status_read),
    .wave_mode(wave_mode), .ext_event_select(ext_event_select),
    .ext_event_edge(ext_event_edge), .count_tick(count_tick),
    .timer_line_a_oe(timer_line_a_oe), .timer_line_b_oe(timer_line_b_oe),
    .counter_value_reg(counter_value_reg), .capture_a_reg(capture_a_reg),
    .capture_b_value(capture_b_value), .load_overrun_flag(load_overrun_flag),
    .counter_clock_enabled(counter_clock_enabled),
    .counter_clock_running(counter_clock_running)
);

// *** sim/timer_line_model.sv ***
`timescale 1ns/1ns
module timer_line_model (
    // Clock
    input wire logic clk_sys,
    // Design side of the lines
    input wire logic line_a_out,
    input wire logic line_a_oe,
    input wire logic line_b_out,
    input wire logic line_b_oe,
    // Levels seen by the design
    output logic line_a,
    output logic line_b,
    output logic [2:0] ext_clk
);
    logic [4:0] lvl = 5'h00;
    // Undriven lines follow the model's own level, low except during a pulse
    assign line_a = line_a_oe ? line_a_out : lvl[0];
    assign line_b = line_b_oe ? line_b_out : lvl[1];
    assign ext_clk = lvl[4:2];
    // Three cycles per level so no edge can slip past the sampler
    task automatic pulse(input int sel);
        @(negedge clk_sys);
        lvl[sel] = 1'b1;
        repeat (3) @(negedge clk_sys);
        lvl[sel] = 1'b0;
        repeat (3) @(negedge clk_sys);
    endtask : pulse
endmodule : timer_line_model

// *** sim/tb.sv ***
`timescale 1ns/1ns
module tb
    import timer_tcw_pkg::*;
;
    logic clk_sys = 1'b0, srst = 1'b1, count_tick = 1'b0, wave_mode = 1'b0;
    logic clk_enable_cmd = 1'b0, clk_disable_cmd = 1'b0, status_read = 1'b0;
    logic software_trigger_cmd = 1'b0, block_sync_cmd = 1'b0;
    logic capture_a_read = 1'b0, capture_b_read = 1'b0;
    logic period_compare_trigger_en = 1'b0, ab_trigger_select = 1'b0;
    logic ext_event_trigger_en = 1'b0, gray_count_enable = 1'b0;
    logic period_compare_stop = 1'b0, period_compare_disable = 1'b0;
    logic gray_count_down = 1'b0;
    logic [1:0] capture_a_load_edge = 2'h0, capture_b_load_edge = 2'h0;
    logic [1:0] capture_trigger_edge = 2'h0, count_scheme_select = 2'h0;
    logic [1:0] ext_event_select = 2'h0, ext_event_edge = 2'h0;
    logic [1:0] a_act_compare_a = 2'h0, a_act_period = 2'h0;
    logic [1:0] a_act_event = 2'h0, a_act_sw_trigger = 2'h0;
    logic [1:0] b_act_compare_b = 2'h0, b_act_period = 2'h0;
    logic [1:0] b_act_event = 2'h0, b_act_sw_trigger = 2'h0;
    logic [CNT_W-1:0] compare_a_value = CNT_ZERO, compare_b_value = CNT_ZERO;
    logic [CNT_W-1:0] period_compare_value = CNT_ZERO;
    logic [CNT_W-1:0] counter_value_reg, capture_a_reg, capture_b_value;
    logic [2:0] ext_clk;
    logic [1:0] prev;
    logic [1:0] acts [4] = '{ACT_SET, ACT_CLEAR, ACT_TOGGLE, ACT_NONE};
    logic [1:0] gray_seq [8] = '{2'h1, 2'h3, 2'h2, 2'h0,
                                 2'h2, 2'h3, 2'h1, 2'h0};
    logic timer_line_a_in, timer_line_b_in, timer_line_a_out, timer_line_a_oe;
    logic timer_line_b_out, timer_line_b_oe, load_overrun_flag;
    logic counter_clock_enabled, counter_clock_running;
    int n_errors = 0;
    int compares = 0;

    always #4 clk_sys = ~clk_sys;

    timer_trigger_capture_waveform timer_trigger_capture_waveform_inst (
        .clk_sys, .srst, .clk_enable_cmd, .clk_disable_cmd,
        .software_trigger_cmd, .block_sync_cmd, .capture_a_read,
        .capture_b_read, .status_read, .wave_mode, .period_compare_trigger_en,
        .capture_a_load_edge, .capture_b_load_edge, .ab_trigger_select,
        .capture_trigger_edge, .ext_event_select, .ext_event_edge,
        .ext_event_trigger_en, .count_scheme_select, .period_compare_stop,
        .period_compare_disable, .gray_count_enable, .gray_count_down,
        .a_act_compare_a, .a_act_period, .a_act_event, .a_act_sw_trigger,
        .b_act_compare_b, .b_act_period, .b_act_event, .b_act_sw_trigger,
        .compare_a_value, .compare_b_value, .period_compare_value, .count_tick,
        .ext_clock_0(ext_clk[0]), .ext_clock_1(ext_clk[1]),
        .ext_clock_2(ext_clk[2]), .timer_line_a_in, .timer_line_b_in,
        .timer_line_a_out, .timer_line_a_oe, .timer_line_b_out,
        .timer_line_b_oe, .counter_value_reg, .capture_a_reg, .capture_b_value,
        .load_overrun_flag, .counter_clock_enabled, .counter_clock_running);

    timer_line_model timer_line_model_inst (.clk_sys,
        .line_a_out(timer_line_a_out), .line_a_oe(timer_line_a_oe),
        .line_b_out(timer_line_b_out), .line_b_oe(timer_line_b_oe),
        .line_a(timer_line_a_in), .line_b(timer_line_b_in), .ext_clk);

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic end_of_test();
        $display("compares %0d n_errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : end_of_test

    // One tick every other cycle, ending on a settled falling edge
    task automatic tick(input int n);
        repeat (n) begin
            @(negedge clk_sys);
            count_tick = 1'b1;
            @(negedge clk_sys);
            count_tick = 1'b0;
        end
        @(negedge clk_sys);
    endtask : tick

    task automatic cmd(input int k);
        @(negedge clk_sys);
        case (k)
            0: software_trigger_cmd = 1'b1;
            1: block_sync_cmd = 1'b1;
            2: clk_enable_cmd = 1'b1;
            3: clk_disable_cmd = 1'b1;
            4: status_read = 1'b1;
            default: {capture_a_read, capture_b_read} = 2'h3;
        endcase
        @(negedge clk_sys);
        {software_trigger_cmd, block_sync_cmd, clk_enable_cmd} = 3'h0;
        {clk_disable_cmd, status_read, capture_a_read, capture_b_read} = 4'h0;
    endtask : cmd

    initial begin
        #200000;
        n_errors++;
        end_of_test();
    end

    initial begin
        repeat (4) @(negedge clk_sys);
        srst = 1'b0;
        check(timer_line_a_oe, 0);
        cmd(0); tick(1); check(counter_clock_running, 0);
        cmd(2); cmd(0); tick(1); check(counter_clock_running, 1);
        tick(5); cmd(0); check(counter_value_reg, 5);
        tick(1); check(counter_value_reg, 0);
        tick(3); cmd(1); tick(1); check(counter_value_reg, 0);
        capture_a_load_edge = EDGE_RISE;
        capture_b_load_edge = EDGE_FALL;
        tick(3); timer_line_model_inst.pulse(0);
        check(capture_a_reg, 3); check(capture_b_value, 3);
        check(load_overrun_flag, 0);
        tick(2); timer_line_model_inst.pulse(0);
        check(capture_a_reg, 5); check(load_overrun_flag, 1);
        cmd(4); check(load_overrun_flag, 0);
        cmd(5); tick(1); timer_line_model_inst.pulse(0);
        check(capture_a_reg, 6); check(load_overrun_flag, 0);
        capture_a_load_edge = EDGE_NONE;
        cmd(0); tick(3); timer_line_model_inst.pulse(0);
        check(capture_b_value, 6);
        capture_a_load_edge = EDGE_RISE;
        capture_b_load_edge = EDGE_NONE;
        timer_line_model_inst.pulse(0); tick(1);
        timer_line_model_inst.pulse(0); check(capture_a_reg, 2);
        ab_trigger_select = 1'b1;
        capture_trigger_edge = EDGE_RISE;
        timer_line_model_inst.pulse(1); tick(1);
        check(counter_value_reg, 4);
        ab_trigger_select = 1'b0;
        timer_line_model_inst.pulse(1); tick(1);
        check(counter_value_reg, 0);
        period_compare_trigger_en = 1'b1;
        period_compare_value = 32'h0000_0002;
        tick(4); check(counter_value_reg, 1);
        capture_trigger_edge = EDGE_NONE;
        wave_mode = 1'b1;
        ext_event_select = EVT_CLK_1;
        ext_event_edge = EDGE_RISE;
        count_scheme_select = SCHEME_UP_PERIOD;
        period_compare_value = 32'h0000_0004;
        a_act_period = ACT_TOGGLE;
        b_act_period = ACT_TOGGLE;
        compare_a_value = CNT_ONE;
        compare_b_value = 32'h0000_0002;
        a_act_compare_a = ACT_SET;
        b_act_compare_b = ACT_SET;
        cmd(0); tick(6); check(counter_value_reg, 0);
        check(timer_line_a_out, 0); check(timer_line_b_out, 0);
        check(timer_line_b_oe, 1);
        count_scheme_select = SCHEME_UP_FULL;
        period_compare_trigger_en = 1'b1;
        period_compare_value = 32'h0000_0002;
        cmd(0); tick(5); check(counter_value_reg, 4);
        ext_event_trigger_en = 1'b1;
        a_act_event = ACT_SET;
        b_act_event = ACT_SET;
        timer_line_model_inst.pulse(3); tick(1);
        check(counter_value_reg, 0); check(timer_line_a_out, 1);
        check(timer_line_b_out, 1);
        ext_event_select = EVT_LINE_B;
        tick(1); check(timer_line_b_oe, 0);
        ext_event_select = EVT_CLK_1;
        ext_event_trigger_en = 1'b0;
        count_scheme_select = SCHEME_UPDN_PERIOD;
        period_compare_value = 32'h0000_0003;
        tick(4); check(counter_value_reg, 1);
        cmd(0); tick(2); check(counter_value_reg, 2);
        count_scheme_select = SCHEME_UP_FULL;
        period_compare_stop = 1'b1;
        cmd(0); tick(6); check(counter_clock_running, 0);
        period_compare_stop = 1'b0;
        period_compare_disable = 1'b1;
        cmd(0); tick(1); check(counter_clock_running, 1);
        tick(5); check(counter_clock_enabled, 0);
        cmd(0); tick(1); check(counter_clock_enabled, 0);
        period_compare_disable = 1'b0;
        cmd(2);
        for (int i = 0; i < 4; i++) begin
            a_act_sw_trigger = acts[i];
            b_act_sw_trigger = acts[i];
            cmd(i == 2);
            check(timer_line_a_out, i != 1);
            check(timer_line_b_out, i != 1);
        end
        count_scheme_select = SCHEME_UP_PERIOD;
        period_compare_value = CNT_ONE;
        gray_count_enable = 1'b1;
        cmd(0); tick(1);
        for (int i = 0; i < 8; i++) begin
            gray_count_down = (i > 3);
            prev = {timer_line_a_out, timer_line_b_out};
            tick(2);
            check($countones(prev ^ {timer_line_a_out, timer_line_b_out}),
                1);
            check({timer_line_b_out, timer_line_a_out},
                gray_seq[i]);
        end
        cmd(3); check(counter_clock_enabled, 0);
        end_of_test();
    end
endmodule : tb
